// ===== mbo_pkg.sv
// Constants, register map and types for the melody and buzzer output unit
package mbo_pkg;
	localparam int unsigned CLK_HZ = 125_000_000;
	localparam int unsigned CLK_PERIOD_NS = 8;
	localparam int unsigned BUZ_FREQ_HZ = 4000;
	localparam int unsigned BUZ_HALF_CYC = CLK_HZ / (2 * BUZ_FREQ_HZ);
	// Tone pitch is TONE_BASE_HZ / (N + 2)
	localparam int unsigned TONE_BASE_HZ = 65536;
	localparam int unsigned TONE_DIV_CYC = CLK_HZ / (2 * TONE_BASE_HZ);
	localparam int unsigned LEN_UNIT_NS = 1953125;
	localparam int unsigned LEN_UNIT_CYC = LEN_UNIT_NS / CLK_PERIOD_NS;

	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_ROUTE = 8'h04;
	localparam logic [7:0] ADDR_TEMPO = 8'h08;
	localparam logic [7:0] ADDR_START = 8'h0C;

	localparam int CTRL_RUN_BIT = 3;
	localparam int CTRL_BEN_BIT = 2;
	localparam int CTRL_MODE_HI = 1;
	localparam int CTRL_MODE_LO = 0;
	localparam int WORD_END_BIT = 15;
	localparam int LEN_HI = 13;
	localparam int LEN_LO = 8;
	localparam int CODE_HI = 6;
	localparam int CODE_LO = 0;
	localparam int REST_LO = 2;
	localparam int ADDR_W = 16;

	localparam logic [1:0] MODE_RST = 2'h0;
	localparam logic [1:0] ROUTE_RST = 2'h0;
	localparam logic [3:0] TEMPO_RST = 4'h0;

	typedef enum logic [1:0] {
		MODE_INT1 = 2'h0,
		MODE_INT2 = 2'h1,
		MODE_SINGLE = 2'h2,
		MODE_CONT = 2'h3
	} mbo_mode_type;

	localparam logic [1:0] ROUTE_VOICE = 2'h0;
	localparam logic [1:0] ROUTE_SPEECH_MEL = 2'h2;
	localparam logic [1:0] ROUTE_SWAP = 2'h3;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_FETCH = 3'h2,
		ST_PLAY = 3'h4
	} mbo_state_type;
endpackage

// ===== mbo_sync3.sv
// Three-stage synchroniser with agreement filter and falling-edge pulse
`timescale 1ns/1ps
module mbo_sync3 (
	input wire logic pclk, // clock
	input wire logic presetn, // async reset, active low
	input wire logic async_in, // level from outside the domain
	output logic level, // filtered level
	output logic fall // one-cycle pulse on a falling level
);
	logic s1;
	logic s2;
	logic s3;
	logic next_level;

	// Level moves only once the last two stages agree
	assign next_level = (s2 == s3) ? s3 : level;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
			level <= 1'b0;
			fall <= 1'b0;
		end
		else
		begin
			s1 <= async_in;
			s2 <= s1;
			s3 <= s2;
			level <= next_level;
			fall <= level & ~next_level;
		end
	end
endmodule

// ===== mbo_melody_buzzer.sv
// Melody sequencer, 4 kHz buzzer and output pin selector with APB registers
`timescale 1ns/1ps
// Operation
// - Melody word bit 15 marks last note
// - Last word raises end request, then stops
// - Buzzer enable drives buzzer onto pin pair
// - Two mode bits pick one of four modes
// - Carrier is 4 kHz square, equal halves
// - Intermittent 1 gates carrier with 8 Hz
// - Intermittent 2 gates with 8 Hz, 1 Hz low
// - Single tone ends at second 32 Hz fall
// - Continuous tone lasts while enable is one
// - Buzzer silent while melody runs
// - Melody start clears buzzer enable
// - Routing bits select pin pair sources
// - Start write supplies melody address, starts playback
// - Words fetched automatically until last note
// - Writing running flag zero stops melody
// - Writing one resumes at following note
// - Running flag is readable
// - Enable zero stops buzzer except single tone
// - Running flag tracks melody playback, rests and fetches included
// - Length bits 13..8, tone code 6..0
module mbo_melody_buzzer
	import mbo_pkg::*;
#(
	parameter int unsigned BUZ_HALF = BUZ_HALF_CYC, // cycles per carrier half period
	parameter int unsigned LEN_UNIT = LEN_UNIT_CYC // cycles per tone length unit
)
(
	input wire logic pclk, // clock, 125 MHz
	input wire logic presetn, // async reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB access phase
	input wire logic pwrite, // APB direction
	input wire logic [7:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error on unmapped address
	output logic mel_rd_req, // melody word fetch request
	output logic [15:0] mel_rd_addr, // melody word address
	input wire logic [15:0] mel_rd_data, // fetched melody word
	input wire logic mel_rd_ack, // fetched word valid
	input wire logic tb_8hz, // time-base 8 Hz
	input wire logic tb_1hz, // time-base 1 Hz
	input wire logic tb_32hz, // time-base 32 Hz
	input wire logic speech_tone_pos, // speech section melody/buzzer, pos
	input wire logic speech_tone_neg, // speech section melody/buzzer, neg
	input wire logic voice_conv, // speech section voice, converter
	input wire logic voice_analog, // speech section voice, analog
	output logic melody_drive_pos, // melody pin pair, positive
	output logic melody_drive_neg, // melody pin pair, negative
	output logic converter_pin, // converter pin
	output logic analog_pin, // analog pin
	output logic melody_end_irq // pulse when last word starts
);
	mbo_state_type state;
	logic running;
	logic buzzer_enable;
	logic [1:0] mode;
	logic [1:0] route;
	logic [3:0] tempo;
	logic [ADDR_W-1:0] next_addr;
	logic [ADDR_W-1:0] pend_addr;
	logic pend_start;
	logic [15:0] word;
	logic [10:0] len_cnt;
	logic [17:0] len_pre;
	logic [9:0] tone_pre;
	logic [7:0] tone_cnt;
	logic tone_ph;
	logic [13:0] buz_cnt;
	logic carrier;
	logic fall_seen;
	logic err_q;
	logic [31:0] next_rdata;
	logic next_err;
	logic tb8;
	logic tb1;
	logic tb32;
	logic tb32_fall;

	// Zero tempo and zero length both act as one
	function automatic logic [10:0] len_units(input logic [3:0] tp, input logic [5:0] l);
		logic [4:0] tpe;
		logic [6:0] le;
		tpe = (tp == 4'h0) ? 5'h2 : {1'b0, tp} + 5'h1;
		le = (l == 6'h0) ? 7'h2 : {1'b0, l} + 7'h1;
		// Both factors widened first so the product cannot wrap
		len_units = {6'h0, tpe} * {4'h0, le};
	endfunction

	mbo_sync3 u_sync_8hz (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(tb_8hz),
		.level(tb8),
		.fall()
	);
	mbo_sync3 u_sync_1hz (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(tb_1hz),
		.level(tb1),
		.fall()
	);
	mbo_sync3 u_sync_32hz (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(tb_32hz),
		.level(tb32),
		.fall(tb32_fall)
	);

	// APB decode; zero wait states
	wire acc = psel & penable;
	wire setup = psel & ~penable;
	wire wr_en = acc & pwrite;
	wire ctl_wr = wr_en & (paddr == ADDR_CTRL);
	wire route_wr = wr_en & (paddr == ADDR_ROUTE);
	wire tempo_wr = wr_en & (paddr == ADDR_TEMPO);
	wire start_wr = wr_en & (paddr == ADDR_START);
	assign pready = acc;
	assign pslverr = acc & err_q;

	always_comb
	begin
		next_rdata = 32'h0;
		next_err = 1'b0;
		if (paddr == ADDR_CTRL)
			next_rdata = {28'h0, running, buzzer_enable, mode};
		else if (paddr == ADDR_ROUTE)
			next_rdata = {30'h0, route};
		else if (paddr == ADDR_TEMPO)
			next_rdata = {28'h0, tempo};
		else if (paddr == ADDR_START)
			next_rdata = {16'h0, next_addr};
		else
			next_err = 1'b1;
	end

	// Read data is captured in the setup phase so it comes from a flop
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= 32'h0;
			err_q <= 1'b0;
		end
		else if (setup)
		begin
			prdata <= next_rdata;
			err_q <= next_err;
		end
	end

	// Melody control strobes
	wire resume_wr = ctl_wr & pwdata[CTRL_RUN_BIT] & ~running;
	wire stop_wr = ctl_wr & ~pwdata[CTRL_RUN_BIT];
	wire start_now = start_wr & (state == ST_IDLE);
	wire pend_go = (state == ST_IDLE) & pend_start;
	wire mel_go = start_now | resume_wr | pend_go;
	wire len_tick = (len_pre == 18'(LEN_UNIT - 1));
	wire len_done = (state == ST_PLAY) & len_tick & (len_cnt == 11'h1);
	wire tone_tick = (tone_pre == 10'(TONE_DIV_CYC - 1));
	wire [5:0] len_field = mel_rd_data[LEN_HI:LEN_LO];
	wire [6:0] tone_code = word[CODE_HI:CODE_LO];
	wire rest = (word[CODE_HI:REST_LO] == 5'h0);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			len_pre <= 18'h0;
			tone_pre <= 10'h0;
		end
		else
		begin
			len_pre <= len_tick ? 18'h0 : len_pre + 18'h1;
			tone_pre <= tone_tick ? 10'h0 : tone_pre + 10'h1;
		end
	end

	// Melody sequencer
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state <= ST_IDLE;
			running <= 1'b0;
			next_addr <= '0;
			pend_addr <= '0;
			pend_start <= 1'b0;
			word <= 16'h0;
			len_cnt <= 11'h0;
			melody_end_irq <= 1'b0;
		end
		else
		begin
			melody_end_irq <= 1'b0;
			if (stop_wr)
			begin
				state <= ST_IDLE;
				running <= 1'b0;
				pend_start <= 1'b0;
			end
			else
			begin
				case (state)
					ST_IDLE:
					begin
						if (mel_go)
						begin
							state <= ST_FETCH;
							running <= 1'b1;
							if (start_now)
								next_addr <= pwdata[ADDR_W-1:0];
							else if (pend_go)
							begin
								next_addr <= pend_addr;
								pend_start <= 1'b0;
							end
						end
					end
					ST_FETCH:
					begin
						if (mel_rd_ack)
						begin
							word <= mel_rd_data;
							// Pointer already names the following note for a resume
							next_addr <= next_addr + 16'h1;
							len_cnt <= len_units(tempo, len_field);
							melody_end_irq <= mel_rd_data[WORD_END_BIT];
							state <= ST_PLAY;
						end
					end
					ST_PLAY:
					begin
						if (len_tick)
							len_cnt <= len_cnt - 11'h1;
						if (len_done)
						begin
							if (pend_start)
							begin
								next_addr <= pend_addr;
								pend_start <= 1'b0;
								state <= ST_FETCH;
							end
							else if (word[WORD_END_BIT])
							begin
								state <= ST_IDLE;
								running <= 1'b0;
							end
							else
								state <= ST_FETCH;
						end
					end
					default:
						state <= ST_IDLE;
				endcase
			end
			// A start during playback is queued for the next note boundary
			if (start_wr && state != ST_IDLE)
			begin
				pend_start <= 1'b1;
				pend_addr <= pwdata[ADDR_W-1:0];
			end
		end
	end

	assign mel_rd_req = (state == ST_FETCH);
	assign mel_rd_addr = next_addr;

	// Tone: half period is N+2 base ticks
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tone_cnt <= 8'h0;
			tone_ph <= 1'b0;
		end
		else if (state != ST_PLAY)
		begin
			tone_cnt <= 8'h0;
			tone_ph <= 1'b0;
		end
		else if (tone_tick)
		begin
			if (tone_cnt == 8'h0)
			begin
				tone_cnt <= {1'b0, tone_code} + 8'h1;
				tone_ph <= ~tone_ph;
			end
			else
				tone_cnt <= tone_cnt - 8'h1;
		end
	end

	// Buzzer carrier runs free so the duty stays exact in every mode
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			buz_cnt <= 14'h0;
			carrier <= 1'b0;
		end
		else if (buz_cnt == 14'(BUZ_HALF - 1))
		begin
			buz_cnt <= 14'h0;
			carrier <= ~carrier;
		end
		else
			buz_cnt <= buz_cnt + 14'h1;
	end

	wire single = (mode == MODE_SINGLE);
	wire single_done = buzzer_enable & single & tb32_fall & fall_seen;
	wire wr_ben = pwdata[CTRL_BEN_BIT] | (buzzer_enable & single);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			buzzer_enable <= 1'b0;
			mode <= MODE_RST;
			fall_seen <= 1'b0;
		end
		else
		begin
			if (ctl_wr)
			begin
				buzzer_enable <= wr_ben;
				mode <= pwdata[CTRL_MODE_HI:CTRL_MODE_LO];
			end
			else if (mel_go || single_done)
				buzzer_enable <= 1'b0;
			if (!buzzer_enable || !single)
				fall_seen <= 1'b0;
			else if (tb32_fall)
				fall_seen <= 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			route <= ROUTE_RST;
			tempo <= TEMPO_RST;
		end
		else
		begin
			if (route_wr)
				route <= pwdata[1:0];
			if (tempo_wr)
				tempo <= pwdata[3:0];
		end
	end

	// Buzzer gating per mode, muted behind a running melody
	wire buz_gate = (mode == MODE_INT1) ? tb8 :
		(mode == MODE_INT2) ? (tb8 & ~tb1) : 1'b1;
	wire buz_on = buzzer_enable & ~running & buz_gate;
	wire mel_on = (state == ST_PLAY) & ~rest;
	wire unit_on = mel_on | buz_on;
	wire unit_wave = mel_on ? tone_ph : carrier;
	wire unit_pos = unit_on & unit_wave;
	wire unit_neg = unit_on & ~unit_wave;
	wire swap = (route == ROUTE_SWAP);
	wire conv_mel = (route == ROUTE_SPEECH_MEL);
	wire next_md_pos = swap ? speech_tone_pos : unit_pos;
	wire next_md_neg = swap ? speech_tone_neg : unit_neg;
	wire next_conv = swap ? unit_pos : conv_mel ? speech_tone_pos : voice_conv;
	wire next_ana = swap ? unit_neg : conv_mel ? speech_tone_neg : voice_analog;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			melody_drive_pos <= 1'b0;
			melody_drive_neg <= 1'b0;
			converter_pin <= 1'b0;
			analog_pin <= 1'b0;
		end
		else
		begin
			melody_drive_pos <= next_md_pos;
			melody_drive_neg <= next_md_neg;
			converter_pin <= next_conv;
			analog_pin <= next_ana;
		end
	end

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_last_taken;
		(state == ST_FETCH) && mel_rd_ack && mel_rd_data[WORD_END_BIT] && !stop_wr;
	endsequence
	sequence s_last_done;
		len_done && word[WORD_END_BIT] && !pend_start && !stop_wr;
	endsequence
	sequence s_single_end;
		single_done && !ctl_wr;
	endsequence

	AST_END_IRQ: assert property (s_last_taken |=> melody_end_irq && word[WORD_END_BIT])
		else $error("end request missing on last word");
	AST_IRQ_CAUSE: assert property (melody_end_irq |-> $past(mel_rd_ack) && word[WORD_END_BIT])
		else $error("end request without last-note word");
	AST_END_STOP: assert property (s_last_done |=> !running && state == ST_IDLE)
		else $error("melody did not halt after last word");
	AST_FORCE_STOP: assert property (stop_wr |=> !running && !mel_rd_req)
		else $error("forced stop not honoured");
	AST_RESUME: assert property (resume_wr |=> mel_rd_req && mel_rd_addr == $past(next_addr))
		else $error("resume did not fetch following note");
	AST_SINGLE_END: assert property (s_single_end |=> !buzzer_enable)
		else $error("single tone not cleared at second fall");
	AST_SINGLE_HOLD: assert property ((ctl_wr && !pwdata[CTRL_BEN_BIT] && single && buzzer_enable)
		|=> buzzer_enable)
		else $error("single tone stopped by software");
	AST_BUZ_CLEAR: assert property ((mel_go && !ctl_wr) |=> !buzzer_enable)
		else $error("melody start left buzzer enabled");
	AST_CARRIER: assert property ($changed(carrier) |-> $past(buz_cnt) == 14'(BUZ_HALF - 1))
		else $error("carrier half period wrong");
	AST_MUTE: assert property ((running && !mel_on && !swap) |=> !melody_drive_pos && !melody_drive_neg)
		else $error("buzzer sounding during melody");
	AST_SWAP: assert property (swap |=> melody_drive_pos == $past(speech_tone_pos))
		else $error("swap routing wrong on melody pins");
endmodule

// ===== mbo_mel_rom.sv
// Melody word memory model that answers fetch requests promptly or slowly
`timescale 1ns/1ps
module mbo_mel_rom
(
	input wire logic pclk, // clock
	input wire logic presetn, // async reset, active low
	input wire logic [3:0] ack_delay, // wait cycles before answering
	input wire logic mel_rd_req, // fetch request
	input wire logic [15:0] mel_rd_addr, // word address
	output logic [15:0] mel_rd_data, // fetched word
	output logic mel_rd_ack // word valid
);
	logic [15:0] mem [0:63];
	logic [3:0] wait_cnt;

	// Data scrambles outside the ack cycle so a stale word is never reused
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wait_cnt <= 4'h0;
			mel_rd_ack <= 1'b0;
			mel_rd_data <= 16'h0000;
		end
		else if (mel_rd_req && !mel_rd_ack && wait_cnt >= ack_delay)
		begin
			mel_rd_ack <= 1'b1;
			mel_rd_data <= mem[mel_rd_addr[5:0]];
			wait_cnt <= 4'h0;
		end
		else
		begin
			mel_rd_ack <= 1'b0;
			mel_rd_data <= ~mel_rd_data;
			wait_cnt <= mel_rd_req && !mel_rd_ack ? wait_cnt + 4'h1 : 4'h0;
		end
	end
endmodule

// ===== mbo_melody_buzzer_tb.sv
// Self-checking bench for the melody and buzzer output unit
`timescale 1ns/1ps
module mbo_melody_buzzer_tb;
	import mbo_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic mel_rd_req, mel_rd_ack, melody_end_irq;
	logic [15:0] mel_rd_addr, mel_rd_data;
	logic tb_8hz, tb_1hz, tb_32hz, speech_tone_pos, speech_tone_neg, voice_conv, voice_analog;
	logic melody_drive_pos, melody_drive_neg, converter_pin, analog_pin;
	logic [3:0] ack_delay;
	int n_mismatch, n_compared, n_irq, c, h, i;

	mbo_melody_buzzer #(.BUZ_HALF(4), .LEN_UNIT(8)) dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .mel_rd_req(mel_rd_req),
		.mel_rd_addr(mel_rd_addr), .mel_rd_data(mel_rd_data), .mel_rd_ack(mel_rd_ack),
		.tb_8hz(tb_8hz), .tb_1hz(tb_1hz), .tb_32hz(tb_32hz),
		.speech_tone_pos(speech_tone_pos), .speech_tone_neg(speech_tone_neg),
		.voice_conv(voice_conv), .voice_analog(voice_analog),
		.melody_drive_pos(melody_drive_pos), .melody_drive_neg(melody_drive_neg),
		.converter_pin(converter_pin), .analog_pin(analog_pin),
		.melody_end_irq(melody_end_irq));

	mbo_mel_rom rom (.pclk(pclk), .presetn(presetn), .ack_delay(ack_delay),
		.mel_rd_req(mel_rd_req), .mel_rd_addr(mel_rd_addr), .mel_rd_data(mel_rd_data),
		.mel_rd_ack(mel_rd_ack));

	task end_sim;
		$display("Counts: %0d compared, %0d mismatched", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// Holds the request until pready is seen high at a rising edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge pclk);
			k++;
		end
		while (pready !== 1'b1 && k < 100);
		if (k >= 100)
			chk(1'b0, 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask

	// Counts carrier edges and high cycles on one pin after a settling gap
	task automatic toggles(input logic sel);
		logic p;
		c = 0;
		h = 0;
		repeat (8) @(negedge pclk);
		p = sel ? converter_pin : melody_drive_pos;
		repeat (40)
		begin
			@(negedge pclk);
			if ((sel ? converter_pin : melody_drive_pos) !== p)
				c++;
			p = sel ? converter_pin : melody_drive_pos;
			if (p === 1'b1)
				h++;
		end
	endtask

	// Bounded wait for a fetch, then its address is compared
	task automatic wait_req(input logic [15:0] a);
		int k;
		k = 0;
		@(negedge pclk);
		while (mel_rd_req !== 1'b1 && k < 2000)
		begin
			@(negedge pclk);
			k++;
		end
		if (k >= 2000)
			chk(1'b0, 1'b1);
		chk(mel_rd_addr, a);
	endtask

	always @(posedge pclk)
		if (melody_end_irq === 1'b1)
			n_irq++;

	initial
	begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	initial
	begin
		repeat (20000) @(posedge pclk);
		n_mismatch++;
		end_sim;
	end

	initial
	begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{tb_8hz, tb_1hz, tb_32hz, speech_tone_pos, speech_tone_neg} = 5'b01110;
		{voice_conv, voice_analog, ack_delay} = 6'h20;
		{n_mismatch, n_compared, n_irq} = '0;
		for (i = 0; i < 64; i++)
			rom.mem[i] = 16'h0105;
		rom.mem[17] = 16'h8105;
		rom.mem[32] = 16'h0100;
		rom.mem[33] = 16'h0100;
		rom.mem[34] = 16'h8100;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(negedge pclk);
		chk({melody_drive_pos, melody_drive_neg}, 2'h0);
		for (i = 0; i < 4; i++)
			rd_chk(8'(i * 4), 32'h0);
		rd_chk(8'h10, 32'h0);
		chk(err, 1'b1);
		for (i = 0; i < 4; i++)
		begin
			apb(1'b1, ADDR_CTRL, 32'(i));
			rd_chk(ADDR_CTRL, 32'(i));
		end
		apb(1'b1, ADDR_ROUTE, 32'h0);
		apb(1'b1, ADDR_CTRL, 32'h7);
		toggles(1'b0);
		chk(c, 10);
		chk(h, 20);
		chk(melody_drive_neg, !melody_drive_pos);
		chk({converter_pin, analog_pin}, {voice_conv, voice_analog});
		apb(1'b1, ADDR_ROUTE, 32'h3);
		toggles(1'b1);
		chk(c, 10);
		chk(melody_drive_pos, speech_tone_pos);
		apb(1'b1, ADDR_ROUTE, 32'h2);
		toggles(1'b0);
		chk(c, 10);
		chk(converter_pin, speech_tone_pos);
		apb(1'b1, ADDR_ROUTE, 32'h0);
		apb(1'b1, ADDR_CTRL, 32'h3);
		toggles(1'b0);
		chk(c, 0);
		apb(1'b1, ADDR_CTRL, 32'h4);
		toggles(1'b0);
		chk(c, 0);
		@(posedge pclk);
		tb_8hz <= 1'b1;
		toggles(1'b0);
		chk(c, 10);
		apb(1'b1, ADDR_CTRL, 32'h5);
		toggles(1'b0);
		chk(c, 0);
		@(posedge pclk);
		tb_1hz <= 1'b0;
		toggles(1'b0);
		chk(c, 10);
		@(posedge pclk);
		tb_1hz <= 1'b1;
		apb(1'b1, ADDR_CTRL, 32'h6);
		toggles(1'b0);
		chk(c, 10);
		apb(1'b1, ADDR_CTRL, 32'h2);
		rd_chk(ADDR_CTRL, 32'h6);
		@(posedge pclk);
		tb_32hz <= 1'b0;
		repeat (10) @(posedge pclk);
		rd_chk(ADDR_CTRL, 32'h6);
		tb_32hz <= 1'b1;
		repeat (10) @(posedge pclk);
		tb_32hz <= 1'b0;
		repeat (10) @(posedge pclk);
		rd_chk(ADDR_CTRL, 32'h2);
		toggles(1'b0);
		chk(c, 0);
		apb(1'b1, ADDR_CTRL, 32'h7);
		apb(1'b1, ADDR_START, 32'h10);
		wait_req(16'h0010);
		rd_chk(ADDR_CTRL, 32'hB);
		@(negedge pclk);
		chk(melody_drive_pos | melody_drive_neg, 1'b1);
		wait_req(16'h0011);
		repeat (100) @(negedge pclk);
		rd_chk(ADDR_CTRL, 32'h3);
		rd_chk(ADDR_START, 32'h12);
		chk(n_irq, 1);
		apb(1'b1, ADDR_TEMPO, 32'hF);
		apb(1'b1, ADDR_START, 32'h20);
		wait_req(16'h0020);
		apb(1'b1, ADDR_CTRL, 32'hF);
		toggles(1'b0);
		chk(c, 0);
		apb(1'b1, ADDR_CTRL, 32'h3);
		rd_chk(ADDR_CTRL, 32'h3);
		c = 0;
		repeat (300)
		begin
			@(negedge pclk);
			if (mel_rd_req === 1'b1)
				c++;
		end
		chk(c, 0);
		@(posedge pclk);
		ack_delay <= 4'h3;
		apb(1'b1, ADDR_CTRL, 32'hB);
		wait_req(16'h0021);
		repeat (900) @(negedge pclk);
		rd_chk(ADDR_CTRL, 32'h3);
		chk(n_irq, 2);
		end_sim;
	end
endmodule
